// ==== rtl/opd_pkg.sv ====
/*
  opd_pkg: constants and types for the opcode decoder.
  assumes a single 200 MHz clock domain and byte-wide opcode fetch.
*/
package opd_pkg;

  // ****************************************
  // escape byte, page-one move and post-increment opcodes, and page-2 opcodes
  // ****************************************
  localparam logic [7:0] OPD_PREBYTE = 8'h9e;
  localparam logic [7:0] OPD_OP_MOV_DD = 8'h4e;
  localparam logic [7:0] OPD_OP_MOV_DIXP = 8'h5e;
  localparam logic [7:0] OPD_OP_MOV_IMD = 8'h6e;
  localparam logic [7:0] OPD_OP_MOV_IXPD = 8'h7e;
  localparam logic [7:0] OPD_OP_CBEQ_IX1P = 8'h61;
  localparam logic [7:0] OPD_OP_CBEQ_IXP = 8'h71;
  localparam logic [7:0] OPD_OP_CPX_SP2 = 8'hd3;
  localparam logic [7:0] OPD_OP_AND_SP2 = 8'hd4;
  localparam logic [7:0] OPD_OP_EOR_SP2 = 8'hd8;
  localparam logic [3:0] OPD_HI_RMW_SP1 = 4'h6;
  localparam logic [3:0] OPD_HI_SP2 = 4'hd;
  localparam logic [3:0] OPD_HI_SP1 = 4'he;
  localparam logic [3:0] OPD_LO_CPX = 4'h3;
  localparam logic [3:0] OPD_LO_AND = 4'h4;
  localparam logic [3:0] OPD_LO_EOR = 4'h8;
  // columns of the stack read-modify-write row that have no stack form
  localparam logic [3:0] OPD_LO_RMW_GAP_A = 4'h2;
  localparam logic [3:0] OPD_LO_RMW_GAP_B = 4'h5;
  localparam logic [3:0] OPD_LO_RMW_GAP_C = 4'he;
  localparam logic [7:0] OPD_OP_CBEQ_SP1 = 8'h61;
  localparam logic [7:0] OPD_OP_DBNZ_SP1 = 8'h6b;
  localparam logic [7:0] OPD_OP_TST_SP1 = 8'h6d;

  // ****************************************
  // entry lengths and cycle counts
  // ****************************************
  localparam logic [2:0] OPD_LEN_SP2 = 3'h4;
  localparam logic [2:0] OPD_LEN_SP1 = 3'h3;
  localparam logic [3:0] OPD_CYC_SP2 = 4'h5;
  localparam logic [3:0] OPD_CYC_SP1 = 4'h4;
  localparam logic [3:0] OPD_CYC_RMW_SP1 = 4'h6;
  localparam logic [2:0] OPD_LEN_CBEQ_SP1 = 3'h4;
  localparam logic [3:0] OPD_CYC_CBEQ_SP1 = 4'h6;
  localparam logic [2:0] OPD_LEN_DBNZ_SP1 = 3'h4;
  localparam logic [3:0] OPD_CYC_DBNZ_SP1 = 4'h8;
  localparam logic [3:0] OPD_CYC_TST_SP1 = 4'h5;
  localparam logic [2:0] OPD_LEN_MOV3 = 3'h3;
  localparam logic [2:0] OPD_LEN_MOV2 = 3'h2;
  localparam logic [3:0] OPD_CYC_DD = 4'h5;
  localparam logic [3:0] OPD_CYC_DIXP = 4'h5;
  localparam logic [3:0] OPD_CYC_IMD = 4'h4;
  localparam logic [3:0] OPD_CYC_IXPD = 4'h5;
  localparam logic [2:0] OPD_LEN_CBEQ_IXP = 3'h2;
  localparam logic [2:0] OPD_LEN_CBEQ_IX1P = 3'h3;
  localparam logic [3:0] OPD_CYC_CBEQ_IXP = 4'h5;
  localparam logic [3:0] OPD_CYC_CBEQ_IX1P = 4'h5;

  typedef enum logic [3:0] {
    OPD_MODE_NONE,
    OPD_MODE_STACK_SHORT,
    OPD_MODE_STACK_LONG,
    OPD_MODE_IDX_POST_INC,
    OPD_MODE_IDX_BYTE_POST_INC,
    OPD_MODE_DIR_TO_DIR,
    OPD_MODE_POST_INC_TO_DIR,
    OPD_MODE_IMM_TO_DIR,
    OPD_MODE_DIR_TO_POST_INC
  } opd_mode_t;

  typedef enum logic [3:0] {
    OPD_OP_NONE,
    OPD_OP_SUB,
    OPD_OP_CMP,
    OPD_OP_SBC,
    OPD_OP_COMPARE_INDEX,
    OPD_OP_AND,
    OPD_OP_BIT,
    OPD_OP_LDA,
    OPD_OP_STA,
    OPD_OP_XOR_ACC,
    OPD_OP_ADC,
    OPD_OP_ORA,
    OPD_OP_ADD,
    OPD_OP_MOVE,
    OPD_OP_CBEQ,
    OPD_OP_RMW
  } opd_op_t;

  // source / destination address path selects
  typedef enum logic [2:0] {
    OPD_PATH_NONE,
    OPD_PATH_DIRECT,
    OPD_PATH_IMMEDIATE,
    OPD_PATH_INDEX_POST_INC,
    OPD_PATH_STACK
  } opd_path_t;

endpackage

// ==== rtl/opd_decode.sv ====
/*
  opd_decode: opcode decoder for the escape page, stack-relative,
  post-increment and memory-to-memory move forms.
  assumes the fetch path presents one opcode byte per valid strobe,
  on the same clock, and consumes the registered decode outputs.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - A byte of 9e with no prefix pending is an escape that makes the next byte decode from page two.
// - Each decoded entry gives opcode, operation, form, byte length and cycle count.
// - Stack forms add an 8-bit or a 16-bit offset to the stack pointer.
// - Post-increment indexed forms, no offset or one-byte offset, bump the index.
// - Moves offer direct to direct and post-increment source to direct.
// - Moves also offer immediate to direct and direct to post-increment.
// - Page-two d3 is compare index 16-bit stack, 4 bytes 5 cycles; d4 is and.
// - Page-two d8 is exclusive-or with 16-bit stack offset, 4 bytes 5 cycles.

module opd_decode
  import opd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // opcode byte from fetch path
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // decoded entry
  output logic dec_valid,
  output logic [15:0] dec_opcode,
  output opd_op_t dec_op,
  output opd_mode_t dec_mode,
  output logic [2:0] dec_bytes,
  output logic [3:0] dec_cycles,
  output opd_path_t dec_src_path,
  output opd_path_t dec_dst_path,
  output logic dec_index_post_inc,
  output logic dec_illegal,
  output logic page2_pending
);

  // ****************************************
  // page-two table lookup
  // ****************************************
  typedef struct packed {
    logic ok;
    opd_op_t op;
    opd_mode_t mode;
    logic [2:0] len;
    logic [3:0] cyc;
  } opd_entry_t;

  // alu column shared by the 8-bit and 16-bit stack rows
  function automatic opd_op_t opd_alu_op(input logic [3:0] lo);
    opd_op_t r;
    r = OPD_OP_NONE;
    unique case (lo)
      4'h0: r = OPD_OP_SUB;
      4'h1: r = OPD_OP_CMP;
      4'h2: r = OPD_OP_SBC;
      OPD_LO_CPX: r = OPD_OP_COMPARE_INDEX;
      OPD_LO_AND: r = OPD_OP_AND;
      4'h5: r = OPD_OP_BIT;
      4'h6: r = OPD_OP_LDA;
      4'h7: r = OPD_OP_STA;
      OPD_LO_EOR: r = OPD_OP_XOR_ACC;
      4'h9: r = OPD_OP_ADC;
      4'ha: r = OPD_OP_ORA;
      4'hb: r = OPD_OP_ADD;
      default: r = OPD_OP_NONE;
    endcase
    return r;
  endfunction

  // only columns confirmed for the stack rows are kept; others are illegal
  function automatic opd_entry_t opd_page2(input logic [7:0] b);
    opd_entry_t e;
    e = '0;
    if (b[7:4] == OPD_HI_SP2 && opd_alu_op(b[3:0]) != OPD_OP_NONE) begin
      e = '{1'b1, opd_alu_op(b[3:0]), OPD_MODE_STACK_LONG, OPD_LEN_SP2,
            OPD_CYC_SP2};
    end else if (b[7:4] == OPD_HI_SP1 &&
                 opd_alu_op(b[3:0]) != OPD_OP_NONE) begin
      e = '{1'b1, opd_alu_op(b[3:0]), OPD_MODE_STACK_SHORT, OPD_LEN_SP1,
            OPD_CYC_SP1};
    end else if (b[7:4] == OPD_HI_RMW_SP1 &&
                 !(b[3:0] inside {OPD_LO_RMW_GAP_A, OPD_LO_RMW_GAP_B,
                                  OPD_LO_RMW_GAP_C})) begin
      e = '{1'b1, OPD_OP_RMW, OPD_MODE_STACK_SHORT, OPD_LEN_SP1,
            OPD_CYC_RMW_SP1};
    end
    // entries of the row whose length or timing differ
    if (b == OPD_OP_CBEQ_SP1) begin
      e = '{1'b1, OPD_OP_CBEQ, OPD_MODE_STACK_SHORT, OPD_LEN_CBEQ_SP1,
            OPD_CYC_CBEQ_SP1};
    end
    if (b == OPD_OP_DBNZ_SP1) begin
      e = '{1'b1, OPD_OP_RMW, OPD_MODE_STACK_SHORT, OPD_LEN_DBNZ_SP1,
            OPD_CYC_DBNZ_SP1};
    end
    if (b == OPD_OP_TST_SP1) begin
      e = '{1'b1, OPD_OP_RMW, OPD_MODE_STACK_SHORT, OPD_LEN_SP1,
            OPD_CYC_TST_SP1};
    end
    // compare index, and and exclusive-or, long stack form
    if (b == OPD_OP_CPX_SP2) begin
      e = '{1'b1, OPD_OP_COMPARE_INDEX, OPD_MODE_STACK_LONG, OPD_LEN_SP2,
            OPD_CYC_SP2};
    end
    if (b == OPD_OP_AND_SP2) begin
      e = '{1'b1, OPD_OP_AND, OPD_MODE_STACK_LONG, OPD_LEN_SP2,
            OPD_CYC_SP2};
    end
    if (b == OPD_OP_EOR_SP2) begin
      e = '{1'b1, OPD_OP_XOR_ACC, OPD_MODE_STACK_LONG, OPD_LEN_SP2,
            OPD_CYC_SP2};
    end
    return e;
  endfunction

  // ****************************************
  // page-one forms covered here
  // ****************************************
  function automatic opd_entry_t opd_page1(input logic [7:0] b);
    opd_entry_t e;
    e = '0;
    unique case (b)
      OPD_OP_MOV_DD: e = '{1'b1, OPD_OP_MOVE, OPD_MODE_DIR_TO_DIR,
                           OPD_LEN_MOV3, OPD_CYC_DD};
      OPD_OP_MOV_IXPD: e = '{1'b1, OPD_OP_MOVE, OPD_MODE_POST_INC_TO_DIR,
                             OPD_LEN_MOV2, OPD_CYC_IXPD};
      OPD_OP_MOV_IMD: e = '{1'b1, OPD_OP_MOVE, OPD_MODE_IMM_TO_DIR,
                            OPD_LEN_MOV3, OPD_CYC_IMD};
      OPD_OP_MOV_DIXP: e = '{1'b1, OPD_OP_MOVE, OPD_MODE_DIR_TO_POST_INC,
                             OPD_LEN_MOV2, OPD_CYC_DIXP};
      OPD_OP_CBEQ_IXP: e = '{1'b1, OPD_OP_CBEQ, OPD_MODE_IDX_POST_INC,
                             OPD_LEN_CBEQ_IXP, OPD_CYC_CBEQ_IXP};
      OPD_OP_CBEQ_IX1P: e = '{1'b1, OPD_OP_CBEQ,
                              OPD_MODE_IDX_BYTE_POST_INC,
                              OPD_LEN_CBEQ_IX1P, OPD_CYC_CBEQ_IX1P};
      default: e = '0;
    endcase
    return e;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  opd_entry_t ent;
  logic next_page2_pending;
  logic next_dec_valid;
  logic [15:0] next_dec_opcode;
  opd_op_t next_dec_op;
  opd_mode_t next_dec_mode;
  logic [2:0] next_dec_bytes;
  logic [3:0] next_dec_cycles;
  opd_path_t next_src, next_dst;
  logic next_post_inc, next_illegal;

  always_comb begin
    ent = '0;
    next_page2_pending = page2_pending;
    next_dec_valid = 1'b0;
    next_dec_opcode = dec_opcode;
    next_dec_op = dec_op;
    next_dec_mode = dec_mode;
    next_dec_bytes = dec_bytes;
    next_dec_cycles = dec_cycles;
    next_src = dec_src_path;
    next_dst = dec_dst_path;
    next_post_inc = dec_index_post_inc;
    next_illegal = dec_illegal;
    if (byte_valid) begin
      if (!page2_pending && byte_data == OPD_PREBYTE) begin
        next_page2_pending = 1'b1;
      end else begin
        ent = page2_pending ? opd_page2(byte_data) : opd_page1(byte_data);
        next_page2_pending = 1'b0;
        next_dec_valid = 1'b1;
        next_dec_opcode = page2_pending ? {OPD_PREBYTE, byte_data}
                                        : {8'h00, byte_data};
        next_dec_op = ent.op;
        next_dec_mode = ent.mode;
        next_dec_bytes = ent.len;
        next_dec_cycles = ent.cyc;
        next_illegal = page2_pending && !ent.ok;
        next_src = OPD_PATH_NONE;
        next_dst = OPD_PATH_NONE;
        next_post_inc = 1'b0;
        unique case (ent.mode)
          OPD_MODE_STACK_SHORT, OPD_MODE_STACK_LONG: begin
            next_src = OPD_PATH_STACK;
          end
          OPD_MODE_IDX_POST_INC, OPD_MODE_IDX_BYTE_POST_INC: begin
            next_src = OPD_PATH_INDEX_POST_INC;
            next_post_inc = 1'b1;
          end
          OPD_MODE_DIR_TO_DIR: begin
            next_src = OPD_PATH_DIRECT;
            next_dst = OPD_PATH_DIRECT;
          end
          OPD_MODE_POST_INC_TO_DIR: begin
            next_src = OPD_PATH_INDEX_POST_INC;
            next_dst = OPD_PATH_DIRECT;
            next_post_inc = 1'b1;
          end
          OPD_MODE_IMM_TO_DIR: begin
            next_src = OPD_PATH_IMMEDIATE;
            next_dst = OPD_PATH_DIRECT;
          end
          OPD_MODE_DIR_TO_POST_INC: begin
            next_src = OPD_PATH_DIRECT;
            next_dst = OPD_PATH_INDEX_POST_INC;
            next_post_inc = 1'b1;
          end
          OPD_MODE_NONE: begin
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      page2_pending <= 1'b0;
      dec_valid <= 1'b0;
      dec_opcode <= 16'h0000;
      dec_op <= OPD_OP_NONE;
      dec_mode <= OPD_MODE_NONE;
      dec_bytes <= 3'h0;
      dec_cycles <= 4'h0;
      dec_src_path <= OPD_PATH_NONE;
      dec_dst_path <= OPD_PATH_NONE;
      dec_index_post_inc <= 1'b0;
      dec_illegal <= 1'b0;
    end else begin
      page2_pending <= next_page2_pending;
      dec_valid <= next_dec_valid;
      dec_opcode <= next_dec_opcode;
      dec_op <= next_dec_op;
      dec_mode <= next_dec_mode;
      dec_bytes <= next_dec_bytes;
      dec_cycles <= next_dec_cycles;
      dec_src_path <= next_src;
      dec_dst_path <= next_dst;
      dec_index_post_inc <= next_post_inc;
      dec_illegal <= next_illegal;
    end
  end

endmodule

`default_nettype wire

// ==== sim/opd_decode_checker.sv ====
/* opd_decode_checker: port assertions for opd_decode.
   assumes bind onto opd_decode, one clock, sync active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module opd_decode_checker
  import opd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fetch side
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // decode side
  input wire logic dec_valid,
  input wire logic [15:0] dec_opcode,
  input wire opd_op_t dec_op,
  input wire opd_mode_t dec_mode,
  input wire logic [2:0] dec_bytes,
  input wire logic [3:0] dec_cycles,
  input wire opd_path_t dec_src_path,
  input wire opd_path_t dec_dst_path,
  input wire logic dec_index_post_inc,
  input wire logic dec_illegal,
  input wire logic page2_pending
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic pfx;
  logic takes;
  logic pg2;
  // gated by reset so the first edge after release sees no stale take
  assign pfx = byte_valid && byte_data == OPD_PREBYTE && !page2_pending;
  assign takes = reset_n && byte_valid && !pfx;
  assign pg2 = byte_valid && page2_pending;
  a_prefix_opens: assert property (
    pfx |=> !dec_valid && page2_pending) else $error("prefix not held");
  a_page_two: assert property (
    pg2 |=> dec_opcode[15:8] == OPD_PREBYTE && !page2_pending)
    else $error("page two opcode wrong");
  a_entry_pulse: assert property (
    dec_valid == $past(takes)) else $error("decode pulse wrong");
  a_post_inc_flag: assert property (
    dec_valid && dec_mode inside {OPD_MODE_IDX_POST_INC,
    OPD_MODE_IDX_BYTE_POST_INC, OPD_MODE_POST_INC_TO_DIR,
    OPD_MODE_DIR_TO_POST_INC} |-> dec_index_post_inc)
    else $error("no post increment");
  a_move_direct: assert property (
    takes && !page2_pending && byte_data == OPD_OP_MOV_DD |=>
    dec_src_path == OPD_PATH_DIRECT && dec_dst_path == OPD_PATH_DIRECT)
    else $error("move paths wrong");
  a_cpx_long: assert property (
    pg2 && byte_data == OPD_OP_CPX_SP2 |=> dec_op == OPD_OP_COMPARE_INDEX
    && dec_bytes == 3'h4 && dec_cycles == 4'h5) else $error("cpx wrong");
  a_eor_long: assert property (
    pg2 && byte_data == OPD_OP_EOR_SP2 |=> dec_op == OPD_OP_XOR_ACC &&
    dec_mode == OPD_MODE_STACK_LONG && !dec_illegal) else $error("xor wrong");
  a_page_one_legal: assert property (
    dec_valid && dec_opcode[15:8] == 8'h00 |-> !dec_illegal)
    else $error("page one flagged");
endmodule
bind opd_decode opd_decode_checker i_opd_decode_checker (
  .clk, .reset_n, .byte_valid, .byte_data, .dec_valid, .dec_opcode, .dec_op,
  .dec_mode, .dec_bytes, .dec_cycles, .dec_src_path, .dec_dst_path,
  .dec_index_post_inc, .dec_illegal, .page2_pending);
`default_nettype wire

// ==== sim/opd_fetch_model.sv ====
/* opd_fetch_model: program-memory fetch path handing opcode bytes.
   assumes the bench calls send and idle from one process. */
`timescale 1ns/1ps
`default_nettype none
module opd_fetch_model (
  // clock
  input wire logic clk,
  // opcode byte
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // ****************************************
  // fetch tasks
  // ****************************************
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h5a;
  end
  // released bus shows inverted data so no stale byte passes as valid
  task automatic idle();
    @(posedge clk);
    #1;
    byte_valid = 1'b0;
    byte_data = ~byte_data;
  endtask
  // gap idle cycles stand for a slow memory
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) idle();
    @(posedge clk);
    #1;
    byte_valid = 1'b1;
    byte_data = b;
  endtask
endmodule
`default_nettype wire

// ==== sim/opd_decode_tb.sv ====
/* opd_decode_tb: scenario bench for the opcode decoder.
   assumes opd_decode with its bound checker and opd_fetch_model. */
`timescale 1ns/1ps
`default_nettype none
module opd_decode_tb
  import opd_pkg::*;
;
  logic clk;
  logic reset_n;
  logic byte_valid;
  logic [7:0] byte_data;
  logic dec_valid;
  logic [15:0] dec_opcode;
  opd_op_t dec_op;
  opd_mode_t dec_mode;
  logic [2:0] dec_bytes;
  logic [3:0] dec_cycles;
  opd_path_t dec_src_path;
  opd_path_t dec_dst_path;
  logic dec_index_post_inc;
  logic dec_illegal;
  logic page2_pending;
  int err_count;
  int n_tests;
  opd_fetch_model i_opd_fetch_model (.clk, .byte_valid, .byte_data);
  opd_decode i_opd_decode (.clk, .reset_n, .byte_valid, .byte_data,
    .dec_valid, .dec_opcode, .dec_op, .dec_mode, .dec_bytes, .dec_cycles,
    .dec_src_path, .dec_dst_path, .dec_index_post_inc, .dec_illegal,
    .page2_pending);
  // ****************************************
  // helpers and scenarios
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [7:0] b, input int gap);
    i_opd_fetch_model.send(b, gap);
  endtask
  task automatic nul();
    i_opd_fetch_model.idle();
  endtask
  task automatic entry(input logic [15:0] opc, input opd_op_t op,
      input opd_mode_t md, input logic [2:0] nb, input logic [3:0] nc,
      input logic pi, input logic ill);
    chk("valid", 16'h0001, 16'(dec_valid));
    chk("opcode", opc, dec_opcode);
    chk("op", 16'(op), 16'(dec_op));
    chk("mode", 16'(md), 16'(dec_mode));
    chk("bytes", 16'(nb), 16'(dec_bytes));
    chk("cycles", 16'(nc), 16'(dec_cycles));
    chk("post inc", 16'(pi), 16'(dec_index_post_inc));
    chk("illegal", 16'(ill), 16'(dec_illegal));
  endtask
  task automatic s_page_two_alu();
    put(OPD_PREBYTE, 0);
    put(OPD_OP_CPX_SP2, 0);
    put(OPD_PREBYTE, 0);
    entry(16'h9ed3, OPD_OP_COMPARE_INDEX, OPD_MODE_STACK_LONG,
      3'h4, 4'h5, 1'b0, 1'b0);
    put(OPD_OP_AND_SP2, 0);
    chk("prefix pulse", 16'h0000, 16'(dec_valid));
    chk("pending", 16'h0001, 16'(page2_pending));
    nul();
    entry(16'h9ed4, OPD_OP_AND, OPD_MODE_STACK_LONG,
      3'h4, 4'h5, 1'b0, 1'b0);
    put(OPD_PREBYTE, 2);
    put(OPD_OP_EOR_SP2, 3);
    chk("held page", 16'h0001, 16'(page2_pending));
    nul();
    entry(16'h9ed8, OPD_OP_XOR_ACC, OPD_MODE_STACK_LONG,
      3'h4, 4'h5, 1'b0, 1'b0);
    chk("src", 16'(OPD_PATH_STACK), 16'(dec_src_path));
    put(OPD_PREBYTE, 0);
    put(8'he3, 0);
    nul();
    entry(16'h9ee3, OPD_OP_COMPARE_INDEX, OPD_MODE_STACK_SHORT,
      3'h3, 4'h4, 1'b0, 1'b0);
  endtask
  task automatic s_moves();
    logic [7:0] opc [4] = '{8'h4e, 8'h5e, 8'h6e, 8'h7e};
    opd_mode_t md [4] = '{OPD_MODE_DIR_TO_DIR, OPD_MODE_DIR_TO_POST_INC,
      OPD_MODE_IMM_TO_DIR, OPD_MODE_POST_INC_TO_DIR};
    logic [2:0] nb [4] = '{3'h3, 3'h2, 3'h3, 3'h2};
    logic [3:0] nc [4] = '{4'h5, 4'h5, 4'h4, 4'h5};
    opd_path_t src [4] = '{OPD_PATH_DIRECT, OPD_PATH_DIRECT,
      OPD_PATH_IMMEDIATE, OPD_PATH_INDEX_POST_INC};
    opd_path_t dst [4] = '{OPD_PATH_DIRECT, OPD_PATH_INDEX_POST_INC,
      OPD_PATH_DIRECT, OPD_PATH_DIRECT};
    for (int i = 0; i < 4; i++) begin
      put(opc[i], 0);
      nul();
      entry({8'h00, opc[i]}, OPD_OP_MOVE, md[i],
        nb[i], nc[i], i[0], 1'b0);
      chk("src", 16'(src[i]), 16'(dec_src_path));
      chk("dst", 16'(dst[i]), 16'(dec_dst_path));
    end
  endtask
  task automatic s_post_inc();
    put(OPD_OP_CBEQ_IXP, 0);
    put(OPD_OP_CBEQ_IX1P, 0);
    entry(16'h0071, OPD_OP_CBEQ, OPD_MODE_IDX_POST_INC,
      3'h2, 4'h5, 1'b1, 1'b0);
    nul();
    entry(16'h0061, OPD_OP_CBEQ, OPD_MODE_IDX_BYTE_POST_INC,
      3'h3, 4'h5, 1'b1, 1'b0);
  endtask
  task automatic s_illegal();
    put(OPD_PREBYTE, 0);
    put(OPD_PREBYTE, 0);
    nul();
    entry(16'h9e9e, OPD_OP_NONE, OPD_MODE_NONE, 3'h0, 4'h0, 1'b0, 1'b1);
    put(OPD_PREBYTE, 0);
    put(8'h00, 0);
    nul();
    entry(16'h9e00, OPD_OP_NONE, OPD_MODE_NONE, 3'h0, 4'h0, 1'b0, 1'b1);
    put(OPD_PREBYTE, 0);
    put(8'h6e, 0);
    nul();
    entry(16'h9e6e, OPD_OP_NONE, OPD_MODE_NONE, 3'h0, 4'h0, 1'b0, 1'b1);
    put(OPD_PREBYTE, 0);
    put(8'h6b, 0);
    nul();
    entry(16'h9e6b, OPD_OP_RMW, OPD_MODE_STACK_SHORT, 3'h4, 4'h8, 1'b0, 1'b0);
    put(OPD_PREBYTE, 0);
    put(8'h61, 0);
    nul();
    entry(16'h9e61, OPD_OP_CBEQ, OPD_MODE_STACK_SHORT, 3'h4, 4'h6, 1'b0, 1'b0);
    put(8'h9d, 0);
    nul();
    entry(16'h009d, OPD_OP_NONE, OPD_MODE_NONE, 3'h0, 4'h0, 1'b0, 1'b0);
  endtask
  // a prefix cut off by reset must not bend the next byte into page two
  task automatic s_reset_mid();
    put(OPD_PREBYTE, 0);
    nul();
    reset_n = 1'b0;
    @(posedge clk);
    #1;
    chk("reset pending", 16'h0000, 16'(page2_pending));
    reset_n = 1'b1;
    put(8'hd8, 0);
    nul();
    entry(16'h00d8, OPD_OP_NONE, OPD_MODE_NONE, 3'h0, 4'h0, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    s_page_two_alu();
    s_moves();
    s_post_inc();
    s_illegal();
    s_reset_mid();
    give_verdict();
  end
endmodule
`default_nettype wire
